// ===== rtl/stp_defs.svh
// constants for the smbus temperature register port
`ifndef STP_DEFS_SVH
`define STP_DEFS_SVH
`define STP_ADDR_BASE     7'h48
`define STP_REG_TEMP1     8'h00
`define STP_REG_TEMP2     8'h01
`define STP_REG_CONFIG    8'h02
`define STP_CFG_CH2_LOCAL 1
`define STP_CFG_RESET     8'h00
`define STP_PTR_RESET     8'h00
`define STP_UNMAPPED_READ 8'hff
`endif

// ===== rtl/stp_pkg.sv
// types for the smbus temperature register port
package stp_pkg;
  typedef enum logic [3:0] {
    STP_IDLE, STP_ADDR, STP_ADDR_ACK, STP_CMD, STP_CMD_ACK,
    STP_DATA, STP_DATA_ACK, STP_TX, STP_TX_ACK, STP_IGNORE
  } stp_state_t;
endpackage

// ===== rtl/stp_smbus_port.sv
// smbus slave register port of a two-channel temperature monitor
`timescale 1ns/10ps
`include "stp_defs.svh"

module stp_smbus_port
  import stp_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_n_i,
  // address select strap, static
  input  wire logic [1:0] addr_sel_i,
  // serial pins
  input  wire logic       smb_clk_i,
  input  wire logic       smb_data_i,
  output logic            smb_data_o,
  output logic            smb_data_oe_o,
  // signed temperature results from the converter
  input  wire logic [8:0] temp_remote1_i,
  input  wire logic [8:0] temp_remote2_i,
  input  wire logic [8:0] temp_local_i,
  // channel two source select
  output logic            ch2_local_o
);

  // ----------------------------------------------------------------
  // pin synchronisers and edge detect
  // ----------------------------------------------------------------
  logic [1:0] scl_sync_ff, sda_sync_ff, nxt_scl_sync, nxt_sda_sync;
  logic       scl_d_ff, sda_d_ff, nxt_scl_d, nxt_sda_d;
  logic       scl_rise, scl_fall, start_det, stop_det;
  logic [1:0] sel_meta_ff, sel_sync_ff, nxt_sel_meta, nxt_sel_sync;

  always_comb begin
    nxt_scl_sync = {scl_sync_ff[0], smb_clk_i};
    nxt_sda_sync = {sda_sync_ff[0], smb_data_i};
    nxt_sel_meta = addr_sel_i;
    nxt_sel_sync = sel_meta_ff;
    nxt_scl_d    = scl_sync_ff[1];
    nxt_sda_d    = sda_sync_ff[1];
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_sync_ff <= 2'h3;
      sda_sync_ff <= 2'h3;
      scl_d_ff    <= 1'b1;
      sda_d_ff    <= 1'b1;
      sel_meta_ff <= 2'h0;
      sel_sync_ff <= 2'h0;
    end else begin
      scl_sync_ff <= nxt_scl_sync;
      sda_sync_ff <= nxt_sda_sync;
      scl_d_ff    <= nxt_scl_d;
      sda_d_ff    <= nxt_sda_d;
      sel_meta_ff <= nxt_sel_meta;
      sel_sync_ff <= nxt_sel_sync;
    end
  end

  assign scl_rise  = scl_sync_ff[1] & ~scl_d_ff;
  assign scl_fall  = ~scl_sync_ff[1] & scl_d_ff;
  assign start_det = scl_sync_ff[1] & scl_d_ff & sda_d_ff & ~sda_sync_ff[1];
  assign stop_det  = scl_sync_ff[1] & scl_d_ff & ~sda_d_ff & sda_sync_ff[1];

  // ----------------------------------------------------------------
  // temperature presentation
  // ----------------------------------------------------------------
  // negative readings clip to zero; positive range fits 8 bits unsigned
  function automatic logic [7:0] stp_clip(input logic [8:0] t);
    stp_clip = t[8] ? 8'h00 : t[7:0];
  endfunction

  logic [7:0] cfg_ff, nxt_cfg;
  logic [7:0] ptr_ff, nxt_ptr;
  logic [7:0] rd_value;

  always_comb begin
    case (ptr_ff)
      `STP_REG_TEMP1:  rd_value = stp_clip(temp_remote1_i);
      `STP_REG_TEMP2:  rd_value = cfg_ff[`STP_CFG_CH2_LOCAL] ? stp_clip(temp_local_i)
                                                             : stp_clip(temp_remote2_i);
      `STP_REG_CONFIG: rd_value = cfg_ff;
      default:         rd_value = `STP_UNMAPPED_READ;
    endcase
  end

  // ----------------------------------------------------------------
  // protocol engine
  // ----------------------------------------------------------------
  stp_state_t state_ff, nxt_state;
  logic [2:0] bit_cnt_ff, nxt_bit_cnt;
  logic [7:0] shift_ff, nxt_shift;
  logic       rd_dir_ff, nxt_rd_dir;
  logic       sda_oe_ff, nxt_sda_oe;
  logic       ch2_ff, nxt_ch2;
  logic [6:0] my_addr;

  // only the two low address bits are strappable
  assign my_addr = `STP_ADDR_BASE | {5'h00, sel_sync_ff};

  always_comb begin
    nxt_state   = state_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_shift   = shift_ff;
    nxt_rd_dir  = rd_dir_ff;
    nxt_sda_oe  = sda_oe_ff;
    nxt_ptr     = ptr_ff;
    nxt_cfg     = cfg_ff;
    nxt_ch2     = cfg_ff[`STP_CFG_CH2_LOCAL];
    if (stop_det) begin
      nxt_state  = STP_IDLE;
      nxt_sda_oe = 1'b0;
    end else if (start_det) begin
      // repeated start keeps the pointer for read byte
      nxt_state   = STP_ADDR;
      nxt_bit_cnt = 3'h0;
      nxt_sda_oe  = 1'b0;
    end else begin
      case (state_ff)
        STP_IDLE, STP_IGNORE: begin
        end
        STP_ADDR, STP_CMD, STP_DATA: begin
          if (scl_rise) begin
            nxt_shift   = {shift_ff[6:0], sda_sync_ff[1]};
            nxt_bit_cnt = bit_cnt_ff + 3'h1;
          end
          // the eighth rising edge completes the byte and wraps the counter
          if (scl_rise && bit_cnt_ff == 3'h7) begin
            case (state_ff)
              STP_ADDR: begin
                // seven address bits sit in the shifter, the r/w bit is still on the pin
                if (shift_ff[6:0] == my_addr) begin
                  nxt_rd_dir = sda_sync_ff[1];
                  nxt_state  = STP_ADDR_ACK;
                end else begin
                  nxt_state = STP_IGNORE;
                end
              end
              STP_CMD: begin
                nxt_ptr   = {shift_ff[6:0], sda_sync_ff[1]};
                nxt_state = STP_CMD_ACK;
              end
              default: begin
                if (ptr_ff == `STP_REG_CONFIG) begin
                  nxt_cfg = {shift_ff[6:0], sda_sync_ff[1]};
                end
                nxt_state = STP_DATA_ACK;
              end
            endcase
          end
        end
        STP_ADDR_ACK, STP_CMD_ACK, STP_DATA_ACK: begin
          // ack drive starts on the falling edge, released on the next one
          if (scl_fall) begin
            if (!sda_oe_ff) begin
              nxt_sda_oe = 1'b1;
            end else begin
              nxt_sda_oe  = 1'b0;
              nxt_bit_cnt = 3'h0;
              case (state_ff)
                STP_ADDR_ACK: begin
                  if (rd_dir_ff) begin
                    nxt_state  = STP_TX;
                    nxt_shift  = rd_value;
                    nxt_sda_oe = ~rd_value[7];
                  end else begin
                    nxt_state = STP_CMD;
                  end
                end
                STP_CMD_ACK: nxt_state = STP_DATA;
                default:     nxt_state = STP_IGNORE;
              endcase
            end
          end
        end
        STP_TX: begin
          if (scl_fall) begin
            nxt_bit_cnt = bit_cnt_ff + 3'h1;
            if (bit_cnt_ff == 3'h7) begin
              nxt_sda_oe = 1'b0;
              nxt_state  = STP_TX_ACK;
            end else begin
              nxt_shift  = {shift_ff[6:0], 1'b0};
              nxt_sda_oe = ~shift_ff[6];
            end
          end
        end
        STP_TX_ACK: begin
          // a single byte is returned whatever the master answers
          if (scl_rise) begin
            nxt_state = STP_IGNORE;
          end
        end
        default: nxt_state = STP_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff   <= STP_IDLE;
      bit_cnt_ff <= 3'h0;
      shift_ff   <= 8'h00;
      rd_dir_ff  <= 1'b0;
      sda_oe_ff  <= 1'b0;
      ptr_ff     <= `STP_PTR_RESET;
      cfg_ff     <= `STP_CFG_RESET;
      ch2_ff     <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      bit_cnt_ff <= nxt_bit_cnt;
      shift_ff   <= nxt_shift;
      rd_dir_ff  <= nxt_rd_dir;
      sda_oe_ff  <= nxt_sda_oe;
      ptr_ff     <= nxt_ptr;
      cfg_ff     <= nxt_cfg;
      ch2_ff     <= nxt_ch2;
    end
  end

  // open drain: only ever pulls low
  assign smb_data_o    = 1'b0;
  assign smb_data_oe_o = sda_oe_ff;
  assign ch2_local_o   = ch2_ff;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_ack_after_cmd;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (state_ff == STP_CMD_ACK && scl_fall && !sda_oe_ff && !start_det && !stop_det) |=> sda_oe_ff;
  endproperty
  a_ack_after_cmd: assert property (p_ack_after_cmd) else $error("no ack after command");

  property p_ptr_from_cmd;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (state_ff == STP_CMD && nxt_state == STP_CMD_ACK) |=> ptr_ff == {$past(shift_ff[6:0]), $past(sda_sync_ff[1])};
  endproperty
  a_ptr_from_cmd: assert property (p_ptr_from_cmd) else $error("pointer not loaded");

  property p_ptr_stable;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (state_ff != STP_CMD) |=> $stable(ptr_ff);
  endproperty
  a_ptr_stable: assert property (p_ptr_stable) else $error("pointer changed outside command");

  property p_cfg_only_data;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (state_ff != STP_DATA) |=> $stable(cfg_ff);
  endproperty
  a_cfg_only_data: assert property (p_cfg_only_data) else $error("config changed outside data");

  property p_clip;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (ptr_ff == `STP_REG_TEMP1 && temp_remote1_i[8]) |-> rd_value == 8'h00;
  endproperty
  a_clip: assert property (p_clip) else $error("negative temp not clipped");

  property p_ch2_src;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (ptr_ff == `STP_REG_TEMP2 && cfg_ff[1] && !temp_local_i[8]) |-> rd_value == temp_local_i[7:0];
  endproperty
  a_ch2_src: assert property (p_ch2_src) else $error("channel two source wrong");

  property p_tx_msb;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (state_ff == STP_ADDR_ACK && nxt_state == STP_TX) |=> sda_oe_ff == ~shift_ff[7];
  endproperty
  a_tx_msb: assert property (p_tx_msb) else $error("first bit not msb");

  property p_foreign_addr;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (state_ff == STP_IGNORE) |-> !sda_oe_ff;
  endproperty
  a_foreign_addr: assert property (p_foreign_addr) else $error("drive while ignoring");

  property p_foreign_ignored;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (state_ff == STP_ADDR && scl_rise && bit_cnt_ff == 3'h7 && shift_ff[6:0] != my_addr &&
       !start_det && !stop_det) |=> state_ff == STP_IGNORE;
  endproperty
  a_foreign_ignored: assert property (p_foreign_ignored) else $error("foreign address taken");

  property p_tx_bit;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      (state_ff == STP_TX && scl_fall && bit_cnt_ff != 3'h7 && !start_det && !stop_det)
        |=> sda_oe_ff == ~shift_ff[7];
  endproperty
  a_tx_bit: assert property (p_tx_bit) else $error("data bit out of order");

  property p_ch2_out;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      1'b1 |=> ch2_ff == $past(cfg_ff[`STP_CFG_CH2_LOCAL]);
  endproperty
  a_ch2_out: assert property (p_ch2_out) else $error("channel two select not registered");

  c_write: cover property (@(posedge core_clk_i) state_ff == STP_DATA_ACK);
  c_read:  cover property (@(posedge core_clk_i) state_ff == STP_TX_ACK);
  c_send:  cover property (@(posedge core_clk_i) state_ff == STP_DATA && stop_det);

endmodule

// ===== sim/stp_host_model.sv
// smbus host model driving the serial pins of the temperature port
`timescale 1ns/10ps
module stp_host_model (
  input  wire logic core_clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_low_o
);
  // ----------------------------------------
  // bit level
  // ----------------------------------------
  // slow against the 2 ff synchronisers, data bits move only while clock is low; start and stop move data while clock is high
  localparam int HALF = 12;
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic tick();
    repeat (HALF) @(posedge core_clk_i);
  endtask
  task automatic start();
    sda_low_o <= 1'b0;
    tick();
    scl_o <= 1'b1;
    tick();
    sda_low_o <= 1'b1;
    tick();
    scl_o <= 1'b0;
    tick();
  endtask
  task automatic stop();
    sda_low_o <= 1'b1;
    tick();
    scl_o <= 1'b1;
    tick();
    sda_low_o <= 1'b0;
    tick();
  endtask
  // released line reads the pull-up, never the last driven value
  task automatic xbit(input logic b, output logic r);
    sda_low_o <= ~b;
    tick();
    scl_o <= 1'b1;
    tick();
    r = sda_i;
    scl_o <= 1'b0;
    tick();
  endtask
  task automatic xbyte(input logic [7:0] d, output logic [7:0] q, output logic ack);
    logic n;
    for (int i = 7; i >= 0; i--) xbit(d[i], q[i]);
    xbit(1'b1, n);
    ack = ~n;
  endtask
  // ----------------------------------------
  // transfers: 0 write, 1 read, 2 send, 3 receive byte
  // ----------------------------------------
  task automatic xfer(input logic [6:0] a, input logic [1:0] k, input logic [7:0] c,
                      input logic [7:0] d, output logic [7:0] q, output logic ok);
    logic [7:0] t;
    logic       g;
    ok = 1'b1;
    q = 8'h00;
    start();
    if (k != 2'd3) begin
      xbyte({a, 1'b0}, t, g);
      ok = ok & g;
      xbyte(c, t, g);
      ok = ok & g;
      if (k == 2'd0) begin
        xbyte(d, t, g);
        ok = ok & g;
      end
      if (k == 2'd1) start();
    end
    if (k[0]) begin
      xbyte({a, 1'b1}, t, g);
      ok = ok & g;
      xbyte(8'hff, q, g);
    end
    stop();
  endtask
endmodule

// ===== sim/stp_smbus_port_test.sv
// self-checking bench of the smbus temperature register port
`timescale 1ns/10ps
`include "stp_defs.svh"
module stp_smbus_port_test;
  logic        core_clk_i;
  logic        rst_n_i;
  logic [8:0]  t1, t2, tl;
  logic        dev_data, dev_oe, ch2_local, ok;
  wire         scl, host_low;
  wire         sda = ~host_low & (~dev_oe | dev_data);
  int          err_count = 0;
  int          num_checks = 0;
  int          i;
  logic [31:0] seed;
  logic [7:0]  q, cfg;
  logic [6:0]  dev;

  stp_smbus_port uut (
    .core_clk_i    (core_clk_i),
    .rst_n_i       (rst_n_i),
    .addr_sel_i    (2'h2),
    .smb_clk_i     (scl),
    .smb_data_i    (sda),
    .smb_data_o    (dev_data),
    .smb_data_oe_o (dev_oe),
    .temp_remote1_i(t1),
    .temp_remote2_i(t2),
    .temp_local_i  (tl),
    .ch2_local_o   (ch2_local)
  );
  stp_host_model host (.core_clk_i(core_clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(host_low));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [7:0] clip(input logic [8:0] t);
    return t[8] ? 8'h00 : t[7:0];
  endfunction
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tx(input logic [1:0] k, input logic [7:0] c, input logic [7:0] d);
    host.xfer(dev, k, c, d, q, ok);
    chk("ack", 8'h01, {7'h00, ok});
  endtask
  task automatic wrap_up();
    if (err_count == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // ----------------------------------------
  // clock, watchdog, sequence
  // ----------------------------------------
  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  initial begin
    repeat (90000) @(posedge core_clk_i);
    err_count++;
    wrap_up();
  end
  initial begin
    rst_n_i = 1'b0;
    t1 = 9'h000;
    t2 = 9'h000;
    tl = 9'h000;
    seed = 32'd19533;
    dev = `STP_ADDR_BASE | 7'h02;
    repeat (6) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    chk("oe_rst", 8'h00, {7'h00, dev_oe});
    chk("ch2_rst", 8'h00, {7'h00, ch2_local});
    repeat (8) @(posedge core_clk_i);
    // first passes hold negative and full-scale corner readings
    for (i = 0; i < 6; i++) begin
      seed = xs(seed);
      cfg = {6'h00, i[0], 1'b0};
      t1 <= (i == 0) ? 9'h1ff : seed[8:0];
      t2 <= (i == 0) ? 9'h0ff : seed[17:9];
      tl <= (i == 1) ? 9'h100 : seed[26:18];
      tx(2'd0, `STP_REG_CONFIG, cfg);
      chk("ch2_local", {7'h00, cfg[1]}, {7'h00, ch2_local});
      tx(2'd1, `STP_REG_CONFIG, 8'h00);
      chk("cfg_rd", cfg, q);
      tx(2'd1, `STP_REG_TEMP1, 8'h00);
      chk("temp1", clip(t1), q);
      tx(2'd3, 8'h00, 8'h00);
      chk("temp1_again", clip(t1), q);
      tx(2'd2, `STP_REG_TEMP2, 8'h00);
      tx(2'd3, 8'h00, 8'h00);
      chk("temp2", clip(cfg[1] ? tl : t2), q);
    end
    tx(2'd0, `STP_REG_TEMP1, 8'h5a);
    tx(2'd2, `STP_REG_CONFIG, 8'h00);
    tx(2'd3, 8'h00, 8'h00);
    chk("cfg_kept", cfg, q);
    tx(2'd1, `STP_REG_TEMP1, 8'h00);
    chk("temp1_ro", clip(t1), q);
    tx(2'd1, 8'h07, 8'h00);
    chk("unmapped", `STP_UNMAPPED_READ, q);
    host.xfer(dev ^ 7'h01, 2'd2, 8'h01, 8'h00, q, ok);
    chk("foreign_ack", 8'h00, {7'h00, ok});
    tx(2'd3, 8'h00, 8'h00);
    chk("ptr_kept", `STP_UNMAPPED_READ, q);
    wrap_up();
  end
endmodule
